// ---- logic/sie_ctrl.sv ----
// Interrupt enable register, event status register and interrupt line.
// Assumes register requests come from the serial control bus decoder on core_clk,
// and event levels from logic already on core_clk.
// Functional notes
// - Enable bit 7 lets a finished indirect register access raise the interrupt.
// - Enable bit 6 lets detection of a downstream receiver raise the interrupt.
// - Enable bit 5 passes downstream receiver interrupt requests upstream.
// - Enable bit 4 lets a ready key-selection-vector list raise the interrupt.
// - Enable bit 3 lets a ready receiver key-selection vector raise the interrupt.
// - Enable bit 2 lets an authentication failure or loss raise the interrupt.
// - Enable bit 1 lets a successful authentication raise the interrupt.
// - Enable bit 0 is the global enable; the interrupt output drives only while it is set.
// - Status bit 0 is set whenever any individually enabled event is indicated.
// - A read-only status register one address above holds each event at its enable position.
`include "sie_defs.svh"
module sie_ctrl (
    input wire logic core_clk,                // 125 MHz device clock
    input wire logic rst_n,                   // Async reset, active low
    input wire sie_pkg::sie_req_t req,        // Register read or write request
    input wire sie_pkg::sie_event_t events,   // Event indication levels
    output logic [7:0] rdata,                 // Read data, valid cycle after rd
    output logic rvalid,                      // One-cycle read data strobe
    output logic irq                          // Interrupt to controller, active high
);
    import sie_pkg::*;

    logic [7:0] interrupt_enable_control;
    logic [7:0] interrupt_event_status;
    logic [7:0] next_status;
    logic [7:1] pending;
    logic global_flag;
    logic [6:0] event_bits;
    logic enable_write;
    logic [1:0] read_sel;

    // Register select shared by write and read paths
    // Unmapped addresses select nothing, so they read zero
    function automatic logic [1:0] sie_decode(input logic [7:0] addr);
        logic [1:0] sel;
        sel = 2'h0;
        if (addr == `SIE_ENABLE_ADDR) begin
            sel = 2'h1;
        end else if (addr == `SIE_STATUS_ADDR) begin
            sel = 2'h2;
        end
        return sel;
    endfunction : sie_decode

    // Only the enable register is writable
    assign enable_write = req.wr && (sie_decode(req.addr) == 2'h1);
    assign read_sel = sie_decode(req.addr);

    // Events are held as levels; status simply mirrors them
    // Nothing is sticky, so no set/clear race can arise
    assign event_bits = events;
    assign next_status[7:1] = event_bits;

    // One gate per source; enable bit g guards status bit g
    // Detection itself never looks at the enables
    for (genvar g = 1; g < 8; g++) begin : gen_gate
        assign pending[g] = next_status[g] & interrupt_enable_control[g];
        a_event_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
            (event_bits[g-1] && interrupt_enable_control[g] && interrupt_enable_control[0]) |=> irq)
            else $error("enabled event did not raise irq");
        a_status_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
            1'h1 |=> interrupt_event_status[g] == $past(event_bits[g-1]))
            else $error("status bit does not follow its event");
    end

    assign global_flag = |pending;
    assign next_status[0] = global_flag;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_enable_control <= `SIE_ENABLE_RESET;
        end else if (enable_write) begin
            interrupt_enable_control <= req.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_event_status <= `SIE_STATUS_RESET;
        end else begin
            interrupt_event_status <= next_status;
        end
    end

    // Global enable gates the line only, status keeps reporting
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'h0;
        end else begin
            irq <= global_flag && interrupt_enable_control[`SIE_BIT_GLOBAL];
        end
    end

    // Writes to the status address are ignored: it is read-only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
            rvalid <= 1'h0;
        end else begin
            rvalid <= req.rd;
            if (!req.rd) begin
                rdata <= 8'h00;
            end else if (read_sel == 2'h1) begin
                rdata <= interrupt_enable_control;
            end else if (read_sel == 2'h2) begin
                rdata <= interrupt_event_status;
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    a_irq_needs_global: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq |-> $past(interrupt_enable_control[0]))
        else $error("irq high without global enable");
    a_irq_follows_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
        (global_flag && interrupt_enable_control[0]) |=> irq)
        else $error("irq missed enabled event");
    a_indirect_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (events.indirect_done && interrupt_enable_control[7]) |-> global_flag)
        else $error("indirect done not flagged");
    a_rxdet_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (events.receiver_detect && interrupt_enable_control[6]) |-> global_flag)
        else $error("receiver detect not flagged");
    a_downreq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (events.downstream_request && interrupt_enable_control[5]) |-> global_flag)
        else $error("downstream request not flagged");
    a_list_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (events.key_list_ready && interrupt_enable_control[4]) |-> global_flag)
        else $error("list ready not flagged");
    a_key_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (events.key_vector_ready && interrupt_enable_control[3]) |-> global_flag)
        else $error("key ready not flagged");
    a_fail_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (events.auth_fail && interrupt_enable_control[2]) |-> global_flag)
        else $error("auth fail not flagged");
    a_pass_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (events.auth_pass && interrupt_enable_control[1]) |-> global_flag)
        else $error("auth pass not flagged");
    a_masked_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((events & interrupt_enable_control[7:1]) == 7'h00) |-> !global_flag)
        else $error("global flag without enabled event");
    a_status_tracks: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'h1 |=> interrupt_event_status[7:1] == $past(events))
        else $error("status does not track events");
    a_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.rd && req.addr == `SIE_STATUS_ADDR) |=> rvalid && rdata == $past(interrupt_event_status))
        else $error("status read wrong");

    // Read port: every strobe answered once, idle data is zero
    a_read_strobe: assert property (@(posedge core_clk) disable iff (!rst_n)
        req.rd |=> rvalid)
        else $error("read strobe not answered");
    a_read_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !req.rd |=> !rvalid && rdata == 8'h00)
        else $error("read port active without strobe");
    a_enable_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.rd && req.addr == `SIE_ENABLE_ADDR) |=> rdata == $past(interrupt_enable_control))
        else $error("enable read wrong");
    a_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.rd && req.addr != `SIE_ENABLE_ADDR && req.addr != `SIE_STATUS_ADDR)
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // A read in the same cycle as a write returns the old value
    a_read_old_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.rd && req.wr && req.addr == `SIE_ENABLE_ADDR)
        |=> rdata == $past(interrupt_enable_control))
        else $error("simultaneous read saw new value");

    // Write path: lands next cycle, nothing else moves the enables
    a_enable_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.wr && req.addr == `SIE_ENABLE_ADDR) |=> interrupt_enable_control == $past(req.wdata))
        else $error("enable write lost");
    a_enable_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(req.wr && req.addr == `SIE_ENABLE_ADDR) |=> $stable(interrupt_enable_control))
        else $error("enable changed without a write");
    a_status_ro: assert property (@(posedge core_clk) disable iff (!rst_n)
        (req.wr && req.addr == `SIE_STATUS_ADDR) |=> interrupt_event_status[7:1] == $past(events))
        else $error("status write took effect");

    // Global status bit ignores the global enable on purpose
    a_global_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'h1 |=> interrupt_event_status[0] == $past(|(event_bits & interrupt_enable_control[7:1])))
        else $error("global status bit wrong");
    a_no_enables_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        (interrupt_enable_control[7:1] == 7'h00) |=> !interrupt_event_status[0])
        else $error("global status set with no enables");
    a_events_seen: assert property (@(posedge core_clk) disable iff (!rst_n)
        (event_bits != 7'h00 && interrupt_enable_control[7:1] == 7'h00)
        |=> interrupt_event_status[7:1] != 7'h00)
        else $error("masked event not reported");

    // Interrupt line: only with global enable and an enabled event
    a_irq_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
        !interrupt_enable_control[0] |=> !irq)
        else $error("irq raised with global enable clear");
    a_irq_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !global_flag |=> !irq)
        else $error("irq raised with nothing pending");
    a_irq_has_status: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq |-> interrupt_event_status[0])
        else $error("irq without global status bit");
    a_irq_needs_event: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq |-> $past(event_bits != 7'h00))
        else $error("irq without any event");
endmodule : sie_ctrl

// ---- common/sie_defs.svh ----
// Offsets, field positions and reset values of the interrupt enable block.
// Assumes an 8-bit register port with byte addresses as printed.
`ifndef SIE_DEFS_SVH
`define SIE_DEFS_SVH
`define SIE_ENABLE_ADDR 8'hC6
`define SIE_STATUS_ADDR 8'hC7
`define SIE_ENABLE_RESET 8'h00
`define SIE_STATUS_RESET 8'h00
`define SIE_BIT_INDIRECT 7
`define SIE_BIT_RXDET 6
`define SIE_BIT_DOWNREQ 5
`define SIE_BIT_LISTRDY 4
`define SIE_BIT_KEYRDY 3
`define SIE_BIT_AUTHFAIL 2
`define SIE_BIT_AUTHPASS 1
`define SIE_BIT_GLOBAL 0
`endif

// ---- common/sie_pkg.sv ----
// Types shared by the interrupt enable block.
// Assumes sie_defs.svh sits on the include path.
package sie_pkg;
    // Register access request from the control bus decoder
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sie_req_t;
    // Event indications, one per source, bit order as in the registers
    typedef struct packed {
        logic indirect_done;
        logic receiver_detect;
        logic downstream_request;
        logic key_list_ready;
        logic key_vector_ready;
        logic auth_fail;
        logic auth_pass;
    } sie_event_t;
endpackage : sie_pkg

// ---- dv/sie_host.sv ----
// Host controller model: one-cycle request strobes on the register port.
// Assumes reads are answered one cycle after the strobe edge.
module sie_host (
    input wire logic core_clk, // Device clock
    output sie_pkg::sie_req_t req, // Request to the block
    input wire logic [7:0] rdata, // Read data
    input wire logic rvalid // Read data strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    import sie_pkg::*;
    initial req = '0;
    task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{w, r, a, d};
        @(posedge core_clk);
        req <= '{1'b0, 1'b0, ~a, ~d}; // Released lines must not keep their value
    endtask : put
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        put(1'b0, 1'b1, a, 8'h00);
        #1 d = rvalid ? rdata : 8'hXX;
    endtask : rd
endmodule : sie_host

// ---- dv/tb_serializer_interrupt_enable.sv ----
// Table-driven bench for the interrupt enable block.
// Assumes sie_defs.svh on the include path and the host model in dv/.
`include "sie_defs.svh"
module tb_serializer_interrupt_enable;
    timeunit 1ns;
    timeprecision 1ps;
    import sie_pkg::*;
    typedef struct {logic [7:0] en; logic [6:0] ev; logic [7:0] st; logic irq;} sie_row_t;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    sie_req_t req;
    sie_event_t events = '0;
    logic [7:0] rdata;
    logic [7:0] got;
    logic rvalid;
    logic irq;
    int fail_count = 0;
    int cmp_count = 0;
    sie_row_t rows [10] = '{
        '{8'h81, 7'h40, 8'h81, 1'b1}, '{8'h41, 7'h20, 8'h41, 1'b1},
        '{8'h21, 7'h10, 8'h21, 1'b1}, '{8'h11, 7'h08, 8'h11, 1'b1},
        '{8'h09, 7'h04, 8'h09, 1'b1}, '{8'h05, 7'h02, 8'h05, 1'b1},
        '{8'h03, 7'h01, 8'h03, 1'b1}, '{8'hFE, 7'h7F, 8'hFF, 1'b0},
        '{8'h01, 7'h7F, 8'hFE, 1'b0}, '{8'h7F, 7'h40, 8'h80, 1'b0}};
    sie_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .req(req), .events(events),
        .rdata(rdata), .rvalid(rvalid), .irq(irq));
    sie_host host (.core_clk(core_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    initial forever #4 core_clk = ~core_clk;
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask : chk
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            host.put(1'b1, 1'b0, `SIE_ENABLE_ADDR, rows[i].en);
            events <= rows[i].ev;
            repeat (2) @(posedge core_clk);
            host.rd(`SIE_STATUS_ADDR, got);
            chk("status", rows[i].st, got);
            chk("irq", {7'h00, rows[i].irq}, {7'h00, irq});
            $display("Row %0d done", i);
        end
        // Status address must ignore writes; enable reads back whole
        host.put(1'b1, 1'b0, `SIE_ENABLE_ADDR, 8'hA5);
        host.put(1'b1, 1'b0, `SIE_STATUS_ADDR, 8'h00);
        host.rd(`SIE_ENABLE_ADDR, got);
        chk("enable", 8'hA5, got);
        host.rd(`SIE_STATUS_ADDR, got);
        chk("status", 8'h81, got);
        chk("irq", 8'h01, {7'h00, irq});
        host.rd(8'h42, got);
        chk("unmapped", 8'h00, got);
        $display("Register access test done");
        // Dropping the global enable with an event pending
        host.put(1'b1, 1'b0, `SIE_ENABLE_ADDR, 8'hA4);
        @(posedge core_clk);
        #1 chk("irq", 8'h00, {7'h00, irq});
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        host.rd(`SIE_ENABLE_ADDR, got);
        chk("enable", `SIE_ENABLE_RESET, got);
        $display("Global enable and reset test done");
        close_out();
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        fail_count++;
        close_out();
    end
endmodule : tb_serializer_interrupt_enable
